/* File: rtl/rtcs_top.sv */
// Purpose: register port, slow-domain transfer and prescaler control
// Assumes: slow clock sources arrive as level inputs
// Notes:   slow logic advances only on the slow-clock edge enable
`timescale 1ns/1ns
module rtcs_top (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [4:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic       i_osc_fast,
    input  wire logic       i_osc_khz,
    input  wire logic       i_ext_clk,
    input  wire logic       i_standby,
    input  wire logic       i_debug_halt,
    output logic [7:0]      o_rd_data,
    output logic            o_irq
);
    import rtcs_pkg::*;

    // ****************************************
    // bus-side registers
    // ****************************************
    logic [7:0]  ctrl_main_reg;
    logic [1:0]  int_en_reg;
    logic [1:0]  int_flag_reg;
    logic [7:0]  temp_reg;
    logic        dbg_run_reg;
    logic [1:0]  clk_src_reg;
    logic [7:0]  pit_ctrl_reg;
    logic        pit_ie_reg;
    logic        pit_flag_reg;
    logic        pit_dbg_reg;
    logic [7:0]  rd_data_reg;
    logic        irq_reg;

    // ****************************************
    // slow-domain state
    // ****************************************
    logic [15:0] count_reg;
    logic [2:0]  src_sync_reg;
    logic        pit_out_reg;

    // ****************************************
    // address decode
    // ****************************************
    wire hit_ctrl    = (i_addr == OFF_CONTROL_MAIN);
    wire hit_ien     = (i_addr == OFF_INT_ENABLE);
    wire hit_iflag   = (i_addr == OFF_INT_FLAGS);
    wire hit_temp    = (i_addr == OFF_TEMPORARY);
    wire hit_dbg     = (i_addr == OFF_DEBUG_CONTROL);
    wire hit_src     = (i_addr == OFF_CLOCK_SOURCE);
    wire hit_cnt_lo  = (i_addr == OFF_COUNT_LO);
    wire hit_cnt_hi  = (i_addr == OFF_COUNT_HI);
    wire hit_per_lo  = (i_addr == OFF_PERIOD_LO);
    wire hit_per_hi  = (i_addr == OFF_PERIOD_HI);
    wire hit_cmp_lo  = (i_addr == OFF_COMPARE_LO);
    wire hit_cmp_hi  = (i_addr == OFF_COMPARE_HI);
    wire hit_pctrl   = (i_addr == OFF_PIT_CONTROL);
    wire hit_pien    = (i_addr == OFF_PIT_INT_EN);
    wire hit_pflag   = (i_addr == OFF_PIT_INT_FLAGS);
    wire hit_pdbg    = (i_addr == OFF_PIT_DEBUG);
    wire wr_lo_word  = i_wr & (hit_cnt_lo | hit_per_lo | hit_cmp_lo);

    // ****************************************
    // slow clock source and edge enable
    // ****************************************
    logic src_level;
    assign src_level = (clk_src_reg == SRC_INTERNAL_FAST) ? i_osc_fast :
                       (clk_src_reg == SRC_INTERNAL_KHZ)  ? i_osc_khz  :
                       (clk_src_reg == SRC_EXTERNAL)      ? i_ext_clk  : 1'b0;

    // slow clock is asynchronous, so synchronise first
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            src_sync_reg <= 3'h0;
        end else begin
            src_sync_reg <= {src_sync_reg[1:0], src_level};
        end
    end

    // edge taken from stages two and three only
    wire slow_tick = src_sync_reg[1] & ~src_sync_reg[2];

    // ****************************************
    // transfers into the slow domain
    // ****************************************
    wire         ctrl_busy;
    wire         cnt_busy;
    wire         per_busy;
    wire         cmp_busy;
    wire         pctrl_busy;
    wire         cnt_done;
    wire [7:0]   ctrl_slow;
    wire [15:0]  cnt_slow;
    wire [15:0]  per_slow;
    wire [15:0]  cmp_slow;
    wire [7:0]   pctrl_slow;
    wire [15:0]  word_wr = {i_wr_data, temp_reg};

    // prescaler setting reaches slow logic after two ticks
    // busy set on write, cleared on capture
    rtcs_sync_slot #(.W(8)) u_ctrl_slot (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (i_wr & hit_ctrl),
        .i_data  (i_wr_data),
        .i_tick  (slow_tick),
        .o_busy  (ctrl_busy),
        .o_done  (),
        .o_value (ctrl_slow)
    );

    // count write lands after two ticks
    rtcs_sync_slot #(.W(16)) u_cnt_slot (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (i_wr & hit_cnt_hi),
        .i_data  (word_wr),
        .i_tick  (slow_tick),
        .o_busy  (cnt_busy),
        .o_done  (cnt_done),
        .o_value (cnt_slow)
    );

    rtcs_sync_slot #(.W(16)) u_per_slot (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (i_wr & hit_per_hi),
        .i_data  (word_wr),
        .i_tick  (slow_tick),
        .o_busy  (per_busy),
        .o_done  (),
        .o_value (per_slow)
    );

    rtcs_sync_slot #(.W(16)) u_cmp_slot (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (i_wr & hit_cmp_hi),
        .i_data  (word_wr),
        .i_tick  (slow_tick),
        .o_busy  (cmp_busy),
        .o_done  (),
        .o_value (cmp_slow)
    );

    rtcs_sync_slot #(.W(8)) u_pctrl_slot (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (i_wr & hit_pctrl),
        .i_data  (i_wr_data),
        .i_tick  (slow_tick),
        .o_busy  (pctrl_busy),
        .o_done  (),
        .o_value (pctrl_slow)
    );

    // ****************************************
    // run conditions
    // ****************************************
    // standby stops counter unless run in standby
    wire standby_stop = i_standby & ~ctrl_slow[BIT_RUN_IN_STANDBY];
    wire rtc_halt     = i_debug_halt & ~dbg_run_reg;
    wire pit_halt     = i_debug_halt & ~pit_dbg_reg;
    // slow logic sees the transferred control copies, but reads the debug run bits directly
    wire rtc_run      = ctrl_slow[BIT_COUNTER_ENABLE] & ~standby_stop & ~rtc_halt;
    wire pit_run      = pctrl_slow[BIT_PERIODIC_EN] & ~pit_halt;

    // ****************************************
    // prescaler
    // ****************************************
    wire [PRESC_W-1:0] presc_count;
    wire               presc_pulse;

    // select taken from main control bits six to three
    rtcs_prescaler u_presc (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_run   (rtc_run | pit_run),
        .i_tick  (slow_tick),
        .i_sel   (ctrl_slow[BIT_PRESC_HI:BIT_PRESC_LO]),
        .o_count (presc_count),
        .o_pulse (presc_pulse)
    );

    // ****************************************
    // counter, overflow and compare events
    // ****************************************
    wire         at_top    = (count_reg == per_slow);
    wire [15:0]  count_inc = at_top ? RST_WORD : count_reg + 16'h0001;
    wire         cnt_step  = presc_pulse & rtc_run;
    wire         ev_ovf    = cnt_step & at_top;
    wire         ev_cmp    = cnt_step & (count_inc == cmp_slow);

    // a software load wins over a count step in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            count_reg <= RST_WORD;
        end else if (cnt_done) begin
            count_reg <= cnt_slow;
        end else if (cnt_step) begin
            count_reg <= count_inc;
        end
    end

    // ****************************************
    // periodic output edge
    // ****************************************
    wire [3:0] pit_sel = pctrl_slow[BIT_PRESC_HI:BIT_PRESC_LO];
    // period zero leaves the output idle
    wire       pit_lvl = (pit_sel != 4'h0) & pit_run & presc_count[pit_sel - 4'h1];
    wire       ev_pit  = pit_lvl & ~pit_out_reg;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pit_out_reg <= 1'b0;
        end else begin
            pit_out_reg <= pit_lvl;
        end
    end

    // ****************************************
    // flags: hardware set wins over clear
    // ****************************************
    wire [1:0] flag_clr    = (i_wr & hit_iflag) ? i_wr_data[1:0] : 2'h0;
    wire       pflag_clr   = i_wr & hit_pflag & i_wr_data[0];
    wire [1:0] flag_set    = {ev_cmp, ev_ovf};
    wire [1:0] flag_next   = (int_flag_reg & ~flag_clr) | flag_set;
    wire       pflag_next  = (pit_flag_reg & ~pflag_clr) | ev_pit;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            int_flag_reg <= 2'h0;
            pit_flag_reg <= 1'b0;
            irq_reg      <= 1'b0;
        end else begin
            int_flag_reg <= flag_next;
            pit_flag_reg <= pflag_next;
            irq_reg      <= (|(flag_next & int_en_reg)) | (pflag_next & pit_ie_reg);
        end
    end

    // ****************************************
    // plain register writes
    // ****************************************
    // main control resets to zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_main_reg <= RST_BYTE;
            int_en_reg    <= 2'h0;
            dbg_run_reg   <= 1'b0;
            clk_src_reg   <= SRC_INTERNAL_FAST;
            pit_ctrl_reg  <= RST_BYTE;
            pit_ie_reg    <= 1'b0;
            pit_dbg_reg   <= 1'b0;
        end else if (i_wr) begin
            if (hit_ctrl) begin
                // bits two and one are unused
                ctrl_main_reg <= i_wr_data & 8'hf9;
            end else if (hit_ien) begin
                int_en_reg <= i_wr_data[1:0];
            end else if (hit_dbg) begin
                dbg_run_reg <= i_wr_data[BIT_DEBUG_RUN];
            end else if (hit_src) begin
                clk_src_reg <= i_wr_data[1:0];
            end else if (hit_pctrl) begin
                pit_ctrl_reg <= i_wr_data & 8'h79;
            end else if (hit_pien) begin
                pit_ie_reg <= i_wr_data[0];
            end else if (hit_pdbg) begin
                pit_dbg_reg <= i_wr_data[BIT_DEBUG_RUN];
            end
        end
    end

    // ****************************************
    // shared temporary byte for 16-bit pairs
    // ****************************************
    // low byte write parks data; low byte read parks the high byte
    wire [7:0] hi_byte_of = hit_cnt_lo ? count_reg[15:8] :
                            hit_per_lo ? per_slow[15:8]  : cmp_slow[15:8];
    wire       rd_lo_word = i_rd & (hit_cnt_lo | hit_per_lo | hit_cmp_lo);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            temp_reg <= RST_BYTE;
        end else if (wr_lo_word | (i_wr & hit_temp)) begin
            temp_reg <= i_wr_data;
        end else if (rd_lo_word) begin
            temp_reg <= hi_byte_of;
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    logic [7:0] rd_mux;
    // compare, period, count, main control busy
    wire  [7:0] status_b = {4'h0, cmp_busy, per_busy, cnt_busy, ctrl_busy};
    // periodic control busy in bit zero
    wire  [7:0] pstat_b  = {7'h00, pctrl_busy};

    always_comb begin
        if (hit_ctrl) begin
            rd_mux = ctrl_main_reg;
        end else if (i_addr == OFF_SYNC_STATUS) begin
            rd_mux = status_b;
        end else if (hit_ien) begin
            rd_mux = {6'h00, int_en_reg};
        end else if (hit_iflag) begin
            rd_mux = {6'h00, int_flag_reg};
        end else if (hit_temp) begin
            rd_mux = temp_reg;
        end else if (hit_dbg) begin
            rd_mux = {7'h00, dbg_run_reg};
        end else if (hit_src) begin
            rd_mux = {6'h00, clk_src_reg};
        end else if (hit_cnt_lo) begin
            rd_mux = count_reg[7:0];
        end else if (hit_per_lo) begin
            rd_mux = per_slow[7:0];
        end else if (hit_cmp_lo) begin
            rd_mux = cmp_slow[7:0];
        end else if (hit_cnt_hi | hit_per_hi | hit_cmp_hi) begin
            rd_mux = temp_reg;
        end else if (hit_pctrl) begin
            rd_mux = pit_ctrl_reg;
        end else if (i_addr == OFF_PIT_STATUS) begin
            rd_mux = pstat_b;
        end else if (hit_pien) begin
            rd_mux = {7'h00, pit_ie_reg};
        end else if (hit_pflag) begin
            rd_mux = {7'h00, pit_flag_reg};
        end else if (hit_pdbg) begin
            rd_mux = {7'h00, pit_dbg_reg};
        end else begin
            // unmapped offsets read zero
            rd_mux = RST_BYTE;
        end
    end

    // data valid only in the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_data_reg <= RST_BYTE;
        end else if (i_rd) begin
            rd_data_reg <= rd_mux;
        end else begin
            rd_data_reg <= RST_BYTE;
        end
    end

    assign o_rd_data = rd_data_reg;
    assign o_irq     = irq_reg;
endmodule

/* File: rtl/rtcs_pkg.sv */
// Purpose: shared constants for the counter register block
// Assumes: byte-wide register port, 5-bit offsets
// Notes:   slow-domain values update on slow-clock edge enables
package rtcs_pkg;
    // ****************************************
    // register offsets
    // ****************************************
    localparam logic [4:0] OFF_CONTROL_MAIN  = 5'h00;
    localparam logic [4:0] OFF_SYNC_STATUS   = 5'h01;
    localparam logic [4:0] OFF_INT_ENABLE    = 5'h02;
    localparam logic [4:0] OFF_INT_FLAGS     = 5'h03;
    localparam logic [4:0] OFF_TEMPORARY     = 5'h04;
    localparam logic [4:0] OFF_DEBUG_CONTROL = 5'h05;
    localparam logic [4:0] OFF_CLOCK_SOURCE  = 5'h07;
    localparam logic [4:0] OFF_COUNT_LO      = 5'h08;
    localparam logic [4:0] OFF_COUNT_HI      = 5'h09;
    localparam logic [4:0] OFF_PERIOD_LO     = 5'h0a;
    localparam logic [4:0] OFF_PERIOD_HI     = 5'h0b;
    localparam logic [4:0] OFF_COMPARE_LO    = 5'h0c;
    localparam logic [4:0] OFF_COMPARE_HI    = 5'h0d;
    localparam logic [4:0] OFF_PIT_CONTROL   = 5'h10;
    localparam logic [4:0] OFF_PIT_STATUS    = 5'h11;
    localparam logic [4:0] OFF_PIT_INT_EN    = 5'h12;
    localparam logic [4:0] OFF_PIT_INT_FLAGS = 5'h13;
    localparam logic [4:0] OFF_PIT_DEBUG     = 5'h15;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int          BIT_RUN_IN_STANDBY = 7;
    localparam int          BIT_PRESC_HI       = 6;
    localparam int          BIT_PRESC_LO       = 3;
    localparam int          BIT_COUNTER_ENABLE = 0;
    localparam int          BIT_PERIODIC_EN    = 0;
    localparam int          BIT_DEBUG_RUN      = 0;
    localparam int          BIT_FLAG_OVF       = 0;
    localparam int          BIT_FLAG_CMP       = 1;
    localparam int          BIT_BUSY_CTRL      = 0;
    localparam int          BIT_BUSY_COUNT     = 1;
    localparam int          BIT_BUSY_PERIOD    = 2;
    localparam int          BIT_BUSY_COMPARE   = 3;
    localparam logic [7:0]  RST_BYTE           = 8'h00;
    localparam logic [15:0] RST_WORD           = 16'h0000;

    // ****************************************
    // clock source encodings
    // ****************************************
    localparam logic [1:0] SRC_INTERNAL_FAST = 2'h0;
    localparam logic [1:0] SRC_INTERNAL_KHZ  = 2'h1;
    localparam logic [1:0] SRC_RESERVED      = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL      = 2'h3;

    // ****************************************
    // timing
    // ****************************************
    localparam int         SYNC_SLOW_TICKS = 2;
    localparam int         PRESC_W         = 15;

    // low sel bits set: prescaler pulses once every 2**sel ticks
    function automatic logic [PRESC_W-1:0] pow2_mask(input logic [3:0] sel);
        pow2_mask = PRESC_W'((16'h0001 << sel) - 16'h0001);
    endfunction
endpackage

/* File: rtl/rtcs_sync_slot.sv */
// Purpose: carries one written value into the slow-clock domain
// Assumes: i_tick is a one-cycle slow-clock edge enable
// Notes:   busy rises on write, falls when the value is captured
`timescale 1ns/1ns
module rtcs_sync_slot #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_tick,
    output logic              o_busy,
    output logic              o_done,
    output logic [W-1:0]      o_value
);
    import rtcs_pkg::*;

    logic [W-1:0] pend_reg;
    logic [1:0]   stage_reg;
    logic         busy_reg;
    logic         done_reg;
    logic [W-1:0] value_reg;
    wire          last_tick = busy_reg & i_tick & (stage_reg == 2'(SYNC_SLOW_TICKS - 1));

    // a new write restarts the transfer, so it never loses to the capture
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pend_reg  <= '0;
            stage_reg <= 2'h0;
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            value_reg <= '0;
        end else begin
            done_reg <= 1'b0;
            if (i_load) begin
                pend_reg  <= i_data;
                stage_reg <= 2'h0;
                busy_reg  <= 1'b1;
            end else if (last_tick) begin
                value_reg <= pend_reg;
                busy_reg  <= 1'b0;
                done_reg  <= 1'b1;
            end else if (busy_reg & i_tick) begin
                stage_reg <= stage_reg + 2'h1;
            end
        end
    end

    assign o_busy  = busy_reg;
    assign o_done  = done_reg;
    assign o_value = value_reg;
endmodule

/* File: rtl/rtcs_prescaler.sv */
// Purpose: power-of-two prescaler on slow-clock edge enables
// Assumes: i_tick is one cycle per slow-clock edge
// Notes:   counter held at zero while nothing uses it
`timescale 1ns/1ns
module rtcs_prescaler (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire logic                        i_run,
    input  wire logic                        i_tick,
    input  wire logic [3:0]                  i_sel,
    output logic [rtcs_pkg::PRESC_W-1:0]     o_count,
    output logic                             o_pulse
);
    import rtcs_pkg::*;

    logic [PRESC_W-1:0] cnt_reg;
    logic               pulse_reg;
    wire  [PRESC_W-1:0] mask   = pow2_mask(i_sel);
    wire                at_end = ((cnt_reg & mask) == mask);

    // divide by two to the select
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_reg   <= '0;
            pulse_reg <= 1'b0;
        end else if (!i_run) begin
            cnt_reg   <= '0;
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= i_tick & at_end;
            if (i_tick) begin
                cnt_reg <= cnt_reg + PRESC_W'(1);
            end
        end
    end

    assign o_count = cnt_reg;
    assign o_pulse = pulse_reg;
endmodule

/* File: verif/rtcs_top_asserts.sv */
// Purpose: port-level checks of the counter register block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   shadows only what the bus itself writes
`timescale 1ns/1ns
module rtcs_top_asserts (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic [4:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic       i_osc_fast,
    input wire logic       i_osc_khz,
    input wire logic       i_ext_clk,
    input wire logic       i_standby,
    input wire logic       i_debug_halt,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_irq
);
    logic [7:0] ctl_reg;
    logic       en_reg;
    wire        rd_ctl  = i_rd && i_addr == 5'h00;
    wire        rd_stat = i_rd && i_addr == 5'h01;
    wire        rd_gap  = i_rd && i_addr inside {5'h06, 5'h0e, 5'h0f, 5'h14, [5'h16:5'h1f]};
    wire        en_wr   = i_wr && (i_addr == 5'h02 || i_addr == 5'h12) && i_wr_data != 8'h00;

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ****************
    // bus shadows
    // ****************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctl_reg <= 8'h00;
            en_reg  <= 1'b0;
        end else begin
            if (i_wr && i_addr == 5'h00) ctl_reg <= i_wr_data;
            if (en_wr) en_reg <= 1'b1;
        end
    end

    // ****************
    // properties
    // ****************
    rd_idle_a: assert property (!$past(i_rd) |-> o_rd_data == 8'h00)
        else $error("read data not zero outside a read answer");
    rst_quiet_a: assert property ($fell(i_rst) |-> o_rd_data == 8'h00 && !o_irq)
        else $error("outputs not quiet after reset");
    ctl_read_a: assert property ($past(rd_ctl) |-> o_rd_data == ($past(ctl_reg) & 8'hf9))
        else $error("main control readback wrong");
    ctl_busy_a: assert property (i_wr && i_addr == 5'h00 ##1 rd_stat |=> o_rd_data[0])
        else $error("main control busy not set after write");
    cnt_busy_a: assert property (i_wr && i_addr == 5'h09 ##1 rd_stat |=> o_rd_data[1])
        else $error("count busy not set after write");
    pit_busy_a: assert property (i_wr && i_addr == 5'h10 ##1 i_rd && i_addr == 5'h11
        |=> o_rd_data == 8'h01)
        else $error("periodic busy not set after write");
    stat_hi_a: assert property ($past(rd_stat) |-> o_rd_data[7:4] == 4'h0)
        else $error("status upper bits not zero");
    gap_read_a: assert property ($past(rd_gap) |-> o_rd_data == 8'h00)
        else $error("unmapped read not zero");
    irq_quiet_a: assert property (!en_reg |-> !o_irq)
        else $error("interrupt with no enable written");

    cover property (i_wr && i_addr == 5'h00 ##1 rd_stat);
    cover property ($rose(o_irq));
    cover property ($past(rd_gap));
endmodule

bind rtcs_top rtcs_top_asserts i_rtcs_top_asserts (.i_clk, .i_rst, .i_addr, .i_wr_data,
    .i_wr, .i_rd, .i_osc_fast, .i_osc_khz, .i_ext_clk, .i_standby, .i_debug_halt,
    .o_rd_data, .o_irq);

/* File: verif/tb_rtcs_top.sv */
// Purpose: self-checking bench for the counter register block
// Assumes: slow sources are divided down from i_clk
// Notes:   fast source ticks every 10 clock cycles
`timescale 1ns/1ns
module tb_rtcs_top;
    logic        i_clk        = 1'b0;
    logic        i_rst        = 1'b1;
    logic [4:0]  i_addr       = 5'h00;
    logic [7:0]  i_wr_data    = 8'h00;
    logic        i_wr         = 1'b0;
    logic        i_rd         = 1'b0;
    logic        i_osc_fast   = 1'b0;
    logic        i_osc_khz    = 1'b0;
    logic        i_ext_clk    = 1'b0;
    logic        i_standby    = 1'b0;
    logic        i_debug_halt = 1'b0;
    logic [7:0]  o_rd_data;
    logic        o_irq;
    logic [7:0]  rd_val;
    int          n_mismatch   = 0;
    int          compares     = 0;
    int          cyc          = 0;
    int          a;
    int          b;
    int          c;
    // rows: address, write value, expected readback
    logic [23:0] rows [13]    = '{24'h00fef8, 24'h02ff03, 24'h04a5a5, 24'h05ff01, 24'h07ff03,
                                  24'h070101, 24'h070000, 24'h107e78, 24'h12ff01, 24'h15ff01,
                                  24'h01ff00, 24'h06ff00, 24'h14ff00};

    rtcs_top i_rtcs_top (.i_clk, .i_rst, .i_addr, .i_wr_data, .i_wr, .i_rd, .i_osc_fast,
        .i_osc_khz, .i_ext_clk, .i_standby, .i_debug_halt, .o_rd_data, .o_irq);

    always #5 i_clk = ~i_clk;

    // sources derived from i_clk so divide ratios come out exact
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc % 5 == 4) i_osc_fast <= ~i_osc_fast;
        if (cyc % 7 == 6) i_osc_khz <= ~i_osc_khz;
        if (cyc % 3 == 2) i_ext_clk <= ~i_ext_clk;
    end

    // ****************
    // bus and checks
    // ****************
    task automatic wr(input logic [4:0] ad, input logic [7:0] d);
        // write behind a write: one edge passes with the strobe low
        if (i_wr) @(posedge i_clk);
        i_addr    <= ad;
        i_wr_data <= d;
        i_wr      <= 1'b1;
        @(posedge i_clk);
        i_wr      <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] ad);
        i_addr <= ad;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        // answer stands only until the next edge
        @(posedge i_clk);
        rd_val = o_rd_data;
    endtask

    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic idle();
        logic [7:0] s;
        for (int k = 0; k < 60; k++) begin
            rd(5'h01);
            s = rd_val;
            rd(5'h11);
            if ((s | rd_val) === 8'h00) return;
        end
        n_mismatch++;
        $display("[FAIL] busy exp 00 got %h", s);
        results();
    endtask

    // clear flags, then time the next rising edge of the interrupt
    task automatic nxt(output int t);
        logic p;
        wr(5'h03, 8'h03);
        p = 1'b1;
        for (int k = 0; k < 900; k++) begin
            @(posedge i_clk);
            if (o_irq === 1'b1 && p === 1'b0) begin
                t = cyc;
                return;
            end
            p = o_irq;
        end
        t = -1;
    endtask

    // ****************
    // sequence
    // ****************
    initial begin
        repeat (16) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        for (int ad = 0; ad < 22; ad++) begin
            rd(5'(ad));
            chk("reset value", 8'h00, rd_val);
        end
        foreach (rows[r]) begin
            wr(rows[r][20:16], rows[r][15:8]);
            rd(rows[r][20:16]);
            chk("readback", rows[r][7:0], rd_val);
            idle();
        end
        wr(5'h10, 8'h00);
        rd(5'h11);
        chk("periodic busy", 8'h01, rd_val);
        idle();
        for (int k = 1; k < 4; k++) begin
            wr(5'(6 + 2 * k), 8'(8'h30 + k));
            wr(5'(7 + 2 * k), 8'(8'h10 + k));
            rd(5'h01);
            chk("busy bit", 8'(1 << k), rd_val & 8'(1 << k));
            idle();
            rd(5'(6 + 2 * k));
            chk("low byte", 8'(8'h30 + k), rd_val);
            rd(5'(7 + 2 * k));
            chk("high byte", 8'(8'h10 + k), rd_val);
        end
        // reserved source gives no ticks, so the transfer must hang
        wr(5'h07, 8'h02);
        wr(5'h00, 8'h00);
        repeat (60) @(posedge i_clk);
        rd(5'h01);
        chk("no source busy", 8'h01, rd_val);
        wr(5'h07, 8'h00);
        idle();
        wr(5'h0a, 8'h00);
        wr(5'h0b, 8'h00);
        // count parked at zero so period zero overflows on every step
        wr(5'h08, 8'h00);
        wr(5'h09, 8'h00);
        wr(5'h02, 8'h01);
        wr(5'h12, 8'h00);
        idle();
        for (int s = 0; s < 4; s++) begin
            wr(5'h00, 8'((s << 3) | 1));
            idle();
            nxt(a);
            nxt(b);
            nxt(c);
            chk("overflow spacing", 8'(10 << s), 8'(c - b));
        end
        wr(5'h02, 8'h00);
        rd(5'h03);
        chk("flag kept", 8'h01, rd_val & 8'h01);
        chk("masked irq", 8'h00, {7'h00, o_irq});
        wr(5'h02, 8'h01);
        i_standby <= 1'b1;
        wr(5'h00, 8'h01);
        idle();
        nxt(a);
        chk("standby stop", 8'hff, 8'(a));
        wr(5'h00, 8'h81);
        idle();
        nxt(a);
        chk("standby run", 8'h00, 8'(a < 0));
        wr(5'h05, 8'h00);
        i_debug_halt <= 1'b1;
        nxt(a);
        chk("debug halt", 8'hff, 8'(a));
        i_debug_halt <= 1'b0;
        i_standby <= 1'b0;
        i_rst     <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(5'h00);
        chk("control after reset", 8'h00, rd_val);
        results();
    end
endmodule
